// File: teso_consts.svh
// Purpose: offsets, field positions, reset values and codes of the timer
// Assumes: apb byte addresses, one aligned 32-bit word per register
// Notes:   definitions only
`ifndef TESO_CONSTS_SVH
`define TESO_CONSTS_SVH

// register byte offsets
`define TESO_OFF_MODE      8'h00
`define TESO_OFF_PRESC     8'h04
`define TESO_OFF_CAPCMP    8'h08
`define TESO_OFF_OUTCTL    8'h0C
`define TESO_OFF_CMPA      8'h10
`define TESO_OFF_CMPB      8'h14
`define TESO_OFF_COUNT     8'h18

// timer_mode_control fields
`define TESO_MODE_OVF_BIT  0
`define TESO_MODE_SEL_LO   2
`define TESO_MODE_SEL_HI   3

// prescaler_mode_reg fields
`define TESO_PRESC_CLK_LO  0
`define TESO_PRESC_CLK_HI  1
`define TESO_PRESC_ES_LO   4
`define TESO_PRESC_ES_HI   5

// output_control_reg fields
`define TESO_OUT_EN_BIT    0
`define TESO_OUT_TOGA_BIT  1
`define TESO_OUT_OS_BIT    2
`define TESO_OUT_TOGB_BIT  4
`define TESO_OUT_TRIG_BIT  6

// edge select codes
`define TESO_ES_FALL       2'h0
`define TESO_ES_RISE       2'h1
`define TESO_ES_NONE       2'h2
`define TESO_ES_BOTH       2'h3

// count clock select codes
`define TESO_CK_DIV1       2'h0
`define TESO_CK_DIV2       2'h1
`define TESO_CK_DIV4       2'h2
`define TESO_CK_EVENT      2'h3

// reset values and limits
`define TESO_CNT_MAX       16'hFFFF
`define TESO_RST_CMP       16'h0000
`define TESO_RST_CCC       8'h00

`endif

// File: teso_pkg.sv
// Purpose: types shared by the timer and its trigger filter
// Assumes: constants come from teso_consts.svh
// Notes:   state records hold every flip-flop of a module except the timer's two reset synchroniser flops
package teso_pkg;

  // mode select codes of timer_mode_control
  typedef enum logic [1:0] {
    TESO_STOP = 2'h0,   // counter stopped and cleared
    TESO_FREE = 2'h1,   // free running
    TESO_TRIG = 2'h2,   // clear and start on trigger edge
    TESO_MCLR = 2'h3    // clear and start on match with compare a
  } teso_mode_t;

  // trigger filter state
  typedef struct packed {
    logic samp;         // last raw sample
    logic level;        // accepted level
    logic edge_hit;     // valid edge pulse
  } teso_filt_t;

  // timer state
  typedef struct packed {
    teso_mode_t  mode;
    logic        ovf;
    logic [1:0]  clk_sel;
    logic [1:0]  edge_sel;
    logic [7:0]  ccc;
    logic        out_en;
    logic        tog_a;
    logic        tog_b;
    logic        os_en;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cnt;
    logic [1:0]  psc;
    logic        out;
    logic        irq_a;
    logic        irq_b;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } teso_state_t;

endpackage : teso_pkg

// File: teso_trig_filter.sv
// Purpose: noise filter and valid edge detector for the trigger input
// Assumes: input synchronous to clk, sampled every cycle
// Notes:   a level is accepted only after two equal samples in a row
`timescale 1ns/1ns
`default_nettype none
`include "teso_consts.svh"

module teso_trig_filter
  import teso_pkg::*;
(
  input  wire logic       clk,        // sampling clock
  input  wire logic       rst_n,      // synchronised reset, active low
  input  wire logic       trig_in,    // raw trigger input
  input  wire logic [1:0] edge_sel,   // valid edge kind
  output logic            edge_hit    // one-cycle valid edge pulse
);

  teso_filt_t f_q;
  teso_filt_t f_d;

  // accept a level after two samples, then classify the edge
  always_comb begin
    f_d          = f_q;
    f_d.samp     = trig_in;
    f_d.edge_hit = 1'b0;
    if (trig_in == f_q.samp) begin
      f_d.level = trig_in;
    end
    if (f_d.level != f_q.level) begin
      case (edge_sel)
        `TESO_ES_FALL: f_d.edge_hit = ~f_d.level;
        `TESO_ES_RISE: f_d.edge_hit = f_d.level;
        `TESO_ES_BOTH: f_d.edge_hit = 1'b1;
        default:       f_d.edge_hit = 1'b0;
      endcase
    end
  end

  // level starts low, so a pin high after reset shows a rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  assign edge_hit = f_q.edge_hit;

endmodule : teso_trig_filter
`default_nettype wire

// File: teso_timer.sv
// Purpose: 16-bit timer / event counter with square wave and one-shot
// Assumes: apb slave, zero wait states, trigger input synchronous to clk
// Notes:   count clock is clk, clk/2, clk/4 or the filtered trigger edge
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "teso_consts.svh"

module teso_timer
  import teso_pkg::*;
#(
  parameter int CNT_W = 16                   // counter width
)(
  input  wire logic        clk,              // 125 MHz clock
  input  wire logic        rst_n,            // async reset, active low
  input  wire logic        psel,             // apb select
  input  wire logic        penable,          // apb access phase
  input  wire logic        pwrite,           // apb write
  input  wire logic [7:0]  paddr,            // apb byte address
  input  wire logic [31:0] pwdata,           // apb write data
  output logic             pready,           // apb ready
  output logic             pslverr,          // apb error, unmapped
  output logic [31:0]      prdata,           // apb read data
  input  wire logic        event_trigger_input, // trigger pin
  output logic             timer_output_pin, // timer output
  output logic             match_a_irq,      // compare a match pulse
  output logic             match_b_irq       // compare b match pulse
);

  logic        rst_s1_q;
  logic        rst_s2_q;
  logic        rst_sn;
  logic        trig_edge;
  logic        wr;
  logic        setup;
  logic        running;
  logic        os_ok;
  logic        soft_trg;
  logic        tick;
  logic        restart;
  logic        hit_a;
  logic        hit_b;
  logic        wrap;
  logic [31:0] rd_val;
  logic        rd_ok;
  teso_state_t s_q;
  teso_state_t s_d;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_sn = rst_s2_q;

  // filter keeps tracking while stopped, so a restart sees no stale edge
  teso_trig_filter u_filt (
    .clk      (clk),
    .rst_n    (rst_sn),
    .trig_in  (event_trigger_input),
    .edge_sel (s_q.edge_sel),
    .edge_hit (trig_edge)
  );

  // apb phase decode; writes land only in the ready access cycle
  assign setup = psel & ~penable;
  assign wr    = psel & penable & s_q.pready & pwrite;

  // read multiplexer, evaluated in the setup cycle
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (paddr)
      `TESO_OFF_MODE: begin
        rd_val[`TESO_MODE_SEL_HI:`TESO_MODE_SEL_LO] = s_q.mode;
        rd_val[`TESO_MODE_OVF_BIT] = s_q.ovf;
      end
      `TESO_OFF_PRESC: begin
        rd_val[`TESO_PRESC_CLK_HI:`TESO_PRESC_CLK_LO] = s_q.clk_sel;
        rd_val[`TESO_PRESC_ES_HI:`TESO_PRESC_ES_LO]   = s_q.edge_sel;
      end
      `TESO_OFF_CAPCMP: begin
        rd_val[7:0] = s_q.ccc;
      end
      `TESO_OFF_OUTCTL: begin
        rd_val[`TESO_OUT_EN_BIT]   = s_q.out_en;
        rd_val[`TESO_OUT_TOGA_BIT] = s_q.tog_a;
        rd_val[`TESO_OUT_OS_BIT]   = s_q.os_en;
        rd_val[`TESO_OUT_TOGB_BIT] = s_q.tog_b;
      end
      `TESO_OFF_CMPA: begin
        rd_val[CNT_W-1:0] = s_q.cmp_a;
      end
      `TESO_OFF_CMPB: begin
        rd_val[CNT_W-1:0] = s_q.cmp_b;
      end
      `TESO_OFF_COUNT: begin
        rd_val[CNT_W-1:0] = s_q.cnt;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // run and one-shot qualifiers
  assign running = (s_q.mode != TESO_STOP);
  assign os_ok   = s_q.os_en & (s_q.mode != TESO_MCLR);
  assign soft_trg = wr & (paddr == `TESO_OFF_OUTCTL)
                  & pwdata[`TESO_OUT_TRIG_BIT];

  // count clock: divided clk or filtered trigger edge
  always_comb begin
    case (s_q.clk_sel)
      `TESO_CK_DIV1:  tick = running;
      `TESO_CK_DIV2:  tick = running & s_q.psc[0];
      `TESO_CK_EVENT: tick = running & trig_edge;
      default:        tick = running & (&s_q.psc);
    endcase
  end

  // trigger edge restarts in trigger-clear mode and in any one-shot;
  // the pin stays live in soft one-shot, so noise there retriggers
  assign restart = running
                 & (((s_q.mode == TESO_TRIG) & trig_edge)
                 | (os_ok & (trig_edge | soft_trg)));

  // compare matches at the count clock; a restart masks them
  assign hit_a = tick & ~restart & (s_q.cnt == s_q.cmp_a);
  assign hit_b = tick & ~restart & (s_q.cnt == s_q.cmp_b);

  // overflow: wrap in free-running or trigger-clear mode, or wrap with compare a at all ones
  assign wrap  = tick & ~restart & (s_q.cnt == `TESO_CNT_MAX)
               & ((s_q.mode != TESO_MCLR)
               | (s_q.cmp_a == `TESO_CNT_MAX));

  // next state of registers, counter and output
  always_comb begin
    s_d         = s_q;
    s_d.irq_a   = 1'b0;
    s_d.irq_b   = 1'b0;
    s_d.pready  = setup;
    s_d.pslverr = setup & ~rd_ok;
    if (setup) begin
      s_d.prdata = pwrite ? 32'h0000_0000 : rd_val;
    end

    // software writes
    if (wr) begin
      case (paddr)
        `TESO_OFF_MODE: begin
          s_d.mode = teso_mode_t'(
            pwdata[`TESO_MODE_SEL_HI:`TESO_MODE_SEL_LO]);
          s_d.ovf  = s_q.ovf & pwdata[`TESO_MODE_OVF_BIT];
        end
        `TESO_OFF_PRESC: begin
          s_d.clk_sel  = pwdata[`TESO_PRESC_CLK_HI:`TESO_PRESC_CLK_LO];
          s_d.edge_sel = pwdata[`TESO_PRESC_ES_HI:`TESO_PRESC_ES_LO];
        end
        `TESO_OFF_CAPCMP: begin
          s_d.ccc = pwdata[7:0];
        end
        `TESO_OFF_OUTCTL: begin
          s_d.out_en = pwdata[`TESO_OUT_EN_BIT];
          s_d.tog_a  = pwdata[`TESO_OUT_TOGA_BIT];
          s_d.os_en  = pwdata[`TESO_OUT_OS_BIT];
          s_d.tog_b  = pwdata[`TESO_OUT_TOGB_BIT];
        end
        `TESO_OFF_CMPA: begin
          s_d.cmp_a = pwdata[CNT_W-1:0];
        end
        `TESO_OFF_CMPB: begin
          s_d.cmp_b = pwdata[CNT_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // prescaler runs only while the counter does
    s_d.psc = running ? s_q.psc + 2'h1 : 2'h0;

    // main counter
    if (!running) begin
      s_d.cnt = '0;
    end else if (restart) begin
      s_d.cnt = '0;
    end else if (tick) begin
      if ((s_q.mode == TESO_MCLR) && (s_q.cnt == s_q.cmp_a)) begin
        s_d.cnt = '0;
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end

    // overflow set wins over a software clear in the same cycle
    if (running && wrap) begin
      s_d.ovf = 1'b1;
    end

    // match interrupt pulses
    s_d.irq_a = running & hit_a;
    s_d.irq_b = running & hit_b;

    // output: one-shot windows or toggles; cleared when stopped
    if (!running || restart) begin
      s_d.out = 1'b0;
    end else if (os_ok) begin
      if (hit_a) begin
        s_d.out = (s_q.cmp_a < s_q.cmp_b);
      end else if (hit_b) begin
        s_d.out = (s_q.cmp_b < s_q.cmp_a);
      end
    end else begin
      if (s_q.tog_a && hit_a) begin
        s_d.out = ~s_q.out;
      end else if (s_q.tog_b && hit_b) begin
        s_d.out = ~s_q.out;
      end
    end
    if (!s_d.out_en) begin
      s_d.out = 1'b0;
    end
  end

  // state register; compares reset to zero, software must load them
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      s_q       <= '0;
      s_q.mode  <= TESO_STOP;
      s_q.cmp_a <= `TESO_RST_CMP;
      s_q.cmp_b <= `TESO_RST_CMP;
      s_q.ccc   <= `TESO_RST_CCC;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign pready           = s_q.pready;
  assign pslverr          = s_q.pslverr;
  assign prdata           = s_q.prdata;
  assign timer_output_pin = s_q.out;
  assign match_a_irq      = s_q.irq_a;
  assign match_b_irq      = s_q.irq_b;

endmodule : teso_timer
`default_nettype wire

// File: teso_timer_assertions.sv
// Purpose: port checks of the timer
// Assumes: zero wait apb slave, registered irq pulses
// Notes:   bound into every teso_timer
`timescale 1ns/1ns
`default_nettype none
module teso_timer_assertions (
  input wire logic        clk,                 // clock
  input wire logic        rst_n,               // reset, low
  input wire logic        psel,                // select
  input wire logic        penable,             // access
  input wire logic        pwrite,              // write
  input wire logic [7:0]  paddr,               // address
  input wire logic [31:0] pwdata,              // write data
  input wire logic        pready,              // ready
  input wire logic        pslverr,             // error
  input wire logic [31:0] prdata,              // read data
  input wire logic        event_trigger_input, // trigger
  input wire logic        timer_output_pin,    // output
  input wire logic        match_a_irq,         // match a
  input wire logic        match_b_irq          // match b
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // a finished write; mode or enable writes may move the pin
  logic wr_done;
  assign wr_done = pready && pwrite;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  chk_ready_next: assert property (s_setup |=> s_done)
    else $error("ready missing after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_unmap: assert property (pready && paddr > 8'h18 |-> pslverr)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (pready && paddr[1:0] == 2'h0
    && paddr < 8'h1C |-> !pslverr) else $error("mapped access refused");
  chk_wr_rdzero: assert property (wr_done |-> prdata == 32'h0000_0000)
    else $error("read data on a write");
  chk_irqa_single: assert property (match_a_irq |=> !match_a_irq)
    else $error("match a pulse too long");
  chk_irqb_single: assert property (match_b_irq |=> !match_b_irq)
    else $error("match b pulse too long");
  chk_pin_cause: assert property ($changed(timer_output_pin) |->
    match_a_irq || match_b_irq || $past(wr_done) || $past(wr_done, 2))
    else $error("output moved without a match");
  chk_irq_apart: assert property (!(match_a_irq && match_b_irq))
    else $error("both matches at once");
endmodule : teso_timer_assertions
bind teso_timer teso_timer_assertions u_chk (.clk, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
  .event_trigger_input, .timer_output_pin, .match_a_irq, .match_b_irq);
`default_nettype wire

// File: teso_pulse_src.sv
// Purpose: external pulse source on the trigger pin
// Assumes: bench requests one pulse at a time
// Notes:   pin rests low between pulses
`timescale 1ns/1ns
`default_nettype none
module teso_pulse_src (
  input  wire logic       clk,    // bench clock
  input  wire logic       rst_n,  // reset, low
  input  wire logic       fire,   // start one pulse
  input  wire logic [7:0] hi_len, // high cycles
  output logic            trig    // trigger pin
);
  logic [7:0] left_q;
  // a request while a pulse runs is dropped, never stretched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) left_q <= 8'h00;
    else if (fire && left_q == 8'h00) left_q <= hi_len;
    else if (left_q != 8'h00) left_q <= left_q - 8'h01;
  end
  // steady low outside a pulse keeps soft one-shots quiet
  assign trig = (left_q != 8'h00);
endmodule : teso_pulse_src
`default_nettype wire

// File: teso_timer_tb_top.sv
// Purpose: self-checking bench of the timer
// Assumes: apb master on rising edges, pulse source on the trigger
// Notes:   reads are noted in a queue and matched by a monitor
`timescale 1ns/1ns
`default_nettype none
`include "teso_consts.svh"
module teso_timer_tb_top;
  localparam logic [7:0] MD = `TESO_OFF_MODE;
  localparam logic [7:0] PS = `TESO_OFF_PRESC;
  localparam logic [7:0] OC = `TESO_OFF_OUTCTL;
  localparam logic [7:0] CA = `TESO_OFF_CMPA;
  localparam logic [7:0] CB = `TESO_OFF_CMPB;
  localparam logic [7:0] CT = `TESO_OFF_COUNT;
  logic        clk, rst_n, psel, penable, pwrite, fire;
  logic        pready, pslverr, trig, pin, irq_a, irq_b;
  logic [7:0]  paddr, hi_len;
  logic [31:0] pwdata, prdata;
  logic [31:0] lfsr = 32'h96d2_b3a7;
  logic [32:0] exp_q[$];
  int          fail_count, total_checks, na, nb, w, n0, sq, lo, hi;
  int          evt[4] = '{2, 2, 0, 4};
  teso_timer u_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .prdata, .event_trigger_input(trig),
    .timer_output_pin(pin), .match_a_irq(irq_a), .match_b_irq(irq_b));
  teso_pulse_src u_src (.clk, .rst_n, .fire, .hi_len, .trig);
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  // one transfer; an idle edge after it keeps drives one per step
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 20) check(0, 1);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic pulse(input logic [7:0] len, input int gap);
    fire <= 1'b1;
    hi_len <= len;
    @(posedge clk);
    fire <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask : pulse
  // high time of the next output pulse, bounded both ways
  task automatic width(output int len);
    int n;
    n = 0;
    len = 0;
    while (pin !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    while (pin === 1'b1 && len < 300) begin
      @(posedge clk);
      len++;
    end
  endtask : width
  // read answers are matched against the oldest note
  always @(posedge clk) begin
    na <= na + int'(irq_a === 1'b1);
    nb <= nb + int'(irq_b === 1'b1);
    if (pready === 1'b1 && pwrite === 1'b0) begin
      if (exp_q.size() == 0) check(0, 1);
      else check({pslverr, prdata}, exp_q.pop_front());
    end
  end
  task automatic report_and_stop();
    if (fail_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (80000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
  initial begin
    {rst_n, psel, penable, pwrite, fire, hi_len, paddr, pwdata} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // reset values, read-only counter, unmapped place
    rd(CA, 0);
    rd(MD, 0);
    wr(CT, 32'h0000_0007);
    rd(CT, 0);
    rd(8'h40, 33'h1_0000_0000);
    // every edge kind; the one-cycle glitch must not count
    foreach (evt[i]) begin
      wr(MD, 0);
      wr(PS, {i[1:0], 4'h3});
      wr(CA, 100);
      wr(MD, 32'h0000_000C);
      repeat (2) pulse(4, 10);
      pulse(1, 10);
      rd(CT, evt[i]);
    end
    // clear on compare a, no overflow below all ones
    wr(MD, 0);
    wr(PS, 32'h0000_0013);
    wr(CA, 2);
    wr(MD, 32'h0000_000C);
    n0 = na;
    repeat (4) pulse(4, 10);
    rd(CT, 1);
    check(na - n0, 1);
    rd(MD, 32'h0000_000C);
    // all-ones compare wraps and flags overflow
    wr(MD, 0);
    wr(PS, 0);
    wr(CA, 32'h0000_FFFF);
    wr(MD, 32'h0000_000C);
    repeat (65540) @(posedge clk);
    rd(MD, 32'h0000_000D);
    // square wave with a random period
    lfsr = nxt(lfsr);
    sq = 4 + lfsr[2:0];
    wr(MD, 0);
    wr(OC, 32'h0000_0003);
    wr(CA, sq);
    wr(MD, 32'h0000_000C);
    width(w);
    check(w, sq + 1);
    // soft one-shot, b below a then above
    for (int k = 0; k < 2; k++) begin
      lfsr = nxt(lfsr);
      lo = 8 + lfsr[3:0];
      hi = lo + 6 + lfsr[6:4];
      wr(MD, 0);
      wr(OC, 32'h0000_0005);
      wr(CA, k ? lo : hi);
      wr(CB, k ? hi : lo);
      wr(MD, 32'h0000_0004);
      n0 = nb;
      wr(OC, 32'h0000_0045);
      width(w);
      // the irq tally settles one edge after the pulse ends
      @(posedge clk);
      check(w, hi - lo);
      check(nb - n0, 1);
    end
    // compare a clear mode gives no one-shot
    wr(MD, 0);
    wr(MD, 32'h0000_000C);
    wr(OC, 32'h0000_0045);
    width(w);
    check(w, 0);
    // external edge starts the pulse
    wr(MD, 0);
    wr(PS, 32'h0000_0010);
    wr(MD, 32'h0000_0008);
    pulse(3, 0);
    width(w);
    check(w, hi - lo);
    repeat (4) @(posedge clk);
    check(exp_q.size(), 0);
    report_and_stop();
  end
endmodule : teso_timer_tb_top
`default_nettype wire
